// ===== logic/asf_core.sv
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "asf_regs.svh"

// Contract
// - Status holds result flags and pointer modes.
// - Status is a legal destination for instructions.
// - Computed zero and carry flags override writes.
// - Clear gives upper zero, Z set, rest kept.
// - Bit, swap, move ops leave flags alone.
// - Subtraction carries report inverted borrow.
// - Overflow flags signed result outside range.
// - Operands: W, file register or literal.
// - Single-cycle eight-by-eight multiplier when present.
// - Status sits at address 04h, unbanked.
module asf_core #(
  parameter bit HAS_MULT = 1'b1
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic OP_VALID,
  input asf_pkg::asf_instr_t OP,
  input wire logic [7:0] FILE_RDATA,
  output logic FILE_WE,
  output logic [7:0] FILE_WADDR,
  output logic [7:0] FILE_WDATA,
  output logic [7:0] STATUS,
  output logic [7:0] WORKING_ACCUM,
  output logic [15:0] PROD,
  output asf_pkg::asf_step_t PTR0_STEP,
  output asf_pkg::asf_step_t PTR1_STEP
);

  asf_pkg::asf_calc_t c;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] w_q;
  logic to_file;
  logic to_status;

  // ==========================================================
  // Datapath
  asf_calc #(.HAS_MULT(HAS_MULT)) u_calc (
    .instr(OP),
    .w(w_q),
    .fdata(FILE_RDATA),
    .cin(status_q[`ASF_BIT_C]),
    .c(c)
  );

  function automatic asf_pkg::asf_step_t step_of(input logic [1:0] code);
    case (code)
      2'b00: step_of = asf_pkg::STEP_DEC;
      2'b01: step_of = asf_pkg::STEP_INC;
      default: step_of = asf_pkg::STEP_HOLD;
    endcase
  endfunction

  assign to_file = OP.dest_file || (OP.op == asf_pkg::OP_ACCUM_TO_FILE);
  // The status register answers at one fixed address regardless of bank.
  assign to_status = OP_VALID && c.wr && to_file && (OP.faddr == `ASF_OFS_STATUS);

  // ==========================================================
  // Status register
  always_comb begin
    status_d = status_q;
    if (to_status) begin
      status_d = c.res;
      // Any op touching the zero or carry flags locks the low nibble against the data write.
      if (|c.upd[2:0]) begin
        for (int i = 0; i < 4; i++) begin
          status_d[i] = c.upd[i] ? c.flags[i] : status_q[i];
        end
      end
    end else if (OP_VALID && (c.upd != 4'h0)) begin
      for (int i = 0; i < 4; i++) begin
        status_d[i] = c.upd[i] ? c.flags[i] : status_q[i];
      end
    end else if (WR && (ADDR == `ASF_OFS_STATUS)) begin
      status_d = WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status_q <= `ASF_STATUS_RST;
      PTR0_STEP <= asf_pkg::STEP_HOLD;
      PTR1_STEP <= asf_pkg::STEP_HOLD;
    end else begin
      status_q <= status_d;
      PTR0_STEP <= step_of(status_d[`ASF_BIT_PTR0_HI:`ASF_BIT_PTR0_LO]);
      PTR1_STEP <= step_of(status_d[`ASF_BIT_PTR1_HI:`ASF_BIT_PTR1_LO]);
    end
  end

  assign STATUS = status_q;

  // ==========================================================
  // Working register and product
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      w_q <= `ASF_WORKING_ACCUM_RST;
    end else if (OP_VALID && c.wr && !to_file) begin
      w_q <= c.res;
    end else if (WR && (ADDR == `ASF_OFS_WORKING_ACCUM)) begin
      w_q <= WDATA;
    end
  end

  assign WORKING_ACCUM = w_q;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PROD <= `ASF_PROD_RST;
    end else if (OP_VALID && c.mul) begin
      PROD <= c.prod;
    end
  end

  // ==========================================================
  // File write port toward data memory
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FILE_WE <= 1'b0;
      FILE_WADDR <= 8'h00;
      FILE_WDATA <= 8'h00;
    end else begin
      FILE_WE <= OP_VALID && c.wr && to_file && !to_status;
      FILE_WADDR <= OP.faddr;
      FILE_WDATA <= c.res;
    end
  end

  // ==========================================================
  // Register read port
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `ASF_OFS_STATUS: RDATA <= status_q;
        `ASF_OFS_WORKING_ACCUM: RDATA <= w_q;
        `ASF_OFS_PRODL: RDATA <= PROD[7:0];
        `ASF_OFS_PRODH: RDATA <= PROD[15:8];
        default: RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  logic issue_st;
  assign issue_st = OP_VALID && OP.dest_file && (OP.faddr == `ASF_OFS_STATUS);

  sequence s_clear_status;
    issue_st && (OP.op == asf_pkg::OP_ZERO_FILL);
  endsequence

  sequence s_cleared;
    (STATUS[7:4] == 4'h0) && STATUS[`ASF_BIT_Z] && (STATUS[3] == $past(STATUS[3])) &&
      (STATUS[1:0] == $past(STATUS[1:0]));
  endsequence

  property p_clear;
    s_clear_status |=> s_cleared;
  endproperty
  a_clear: assert property (p_clear) else $error("clear of status wrong");

  property p_bitset;
    issue_st && (OP.op == asf_pkg::OP_BIT_RAISE) && !OP.src_w &&
      (FILE_RDATA == STATUS) |=> STATUS == ($past(STATUS) | (8'h01 << $past(OP.bitsel)));
  endproperty
  a_bitset: assert property (p_bitset) else $error("bit set on status wrong");

  property p_protect;
    issue_st && (OP.op == asf_pkg::OP_ADD) |=>
      (STATUS[2:0] == $past(c.flags[2:0])) && (STATUS[7:4] == $past(c.res[7:4]));
  endproperty
  a_protect: assert property (p_protect) else $error("flags not protected");

  property p_move;
    issue_st && (OP.op == asf_pkg::OP_ACCUM_TO_FILE) |=> STATUS == $past(WORKING_ACCUM);
  endproperty
  a_move: assert property (p_move) else $error("move to status wrong");

  property p_borrow;
    OP_VALID && (OP.op == asf_pkg::OP_SUB) && !OP.dest_file && OP.use_imm &&
      (OP.imm >= WORKING_ACCUM) |=> STATUS[`ASF_BIT_C];
  endproperty
  a_borrow: assert property (p_borrow) else $error("no-borrow carry clear");

  property p_ovf;
    OP_VALID && (OP.op == asf_pkg::OP_ADD) && !OP.dest_file && OP.use_imm &&
      (WORKING_ACCUM == 8'h7f) && (OP.imm == 8'h01) |=>
      STATUS[`ASF_BIT_SIGNED_RANGE] && (WORKING_ACCUM == 8'h80);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow missed");

  property p_imm_add;
    OP_VALID && (OP.op == asf_pkg::OP_ADD) && !OP.dest_file && OP.use_imm |=>
      WORKING_ACCUM == $past(WORKING_ACCUM) + $past(OP.imm);
  endproperty
  a_imm_add: assert property (p_imm_add) else $error("literal add wrong");

  property p_mul;
    OP_VALID && (OP.op == asf_pkg::OP_MUL) && HAS_MULT |=>
      PROD == $past(WORKING_ACCUM) * ($past(OP.use_imm) ? $past(OP.imm) : $past(FILE_RDATA));
  endproperty
  a_mul: assert property (p_mul) else $error("product wrong");

  property p_busw;
    WR && (ADDR == `ASF_OFS_STATUS) && !OP_VALID |=> STATUS == $past(WDATA);
  endproperty
  a_busw: assert property (p_busw) else $error("status bus write lost");

  property p_zero;
    OP_VALID && (OP.op == asf_pkg::OP_AND) && !OP.dest_file |=>
      STATUS[`ASF_BIT_Z] == (WORKING_ACCUM == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_step;
    ##1 (PTR0_STEP == step_of(STATUS[5:4])) && (PTR1_STEP == step_of(STATUS[7:6]));
  endproperty
  a_step: assert property (p_step) else $error("pointer step mismatch");

endmodule

// ===== inc/asf_regs.svh
`ifndef ASF_REGS_SVH
`define ASF_REGS_SVH

// ==========================================================
// Register offsets on the plain register port
`define ASF_OFS_STATUS 8'h04
`define ASF_OFS_WORKING_ACCUM 8'h08
`define ASF_OFS_PRODL 8'h0c
`define ASF_OFS_PRODH 8'h10

// ==========================================================
// Status register field positions
`define ASF_BIT_PTR1_HI 7
`define ASF_BIT_PTR1_LO 6
`define ASF_BIT_PTR0_HI 5
`define ASF_BIT_PTR0_LO 4
`define ASF_BIT_SIGNED_RANGE 3
`define ASF_BIT_Z 2
`define ASF_BIT_HALF_BYTE_BORROW 1
`define ASF_BIT_C 0

// ==========================================================
// Reset values
`define ASF_STATUS_RST 8'hf0
`define ASF_WORKING_ACCUM_RST 8'h00
`define ASF_PROD_RST 16'h0000

`endif

// ===== inc/asf_pkg.sv
package asf_pkg;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADDC, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_INC, OP_DEC,
    OP_RLC, OP_RRC, OP_COM, OP_ZERO_FILL, OP_BIT_DROP, OP_BIT_RAISE,
    OP_NIBBLE_EXCHANGE, OP_ACCUM_TO_FILE, OP_MUL
  } asf_op_t;

  typedef enum logic [1:0] {STEP_DEC, STEP_INC, STEP_HOLD} asf_step_t;

  typedef struct packed {
    asf_op_t op;
    logic use_imm;
    logic src_w;
    logic dest_file;
    logic [7:0] faddr;
    logic [7:0] imm;
    logic [2:0] bitsel;
  } asf_instr_t;

  typedef struct packed {
    logic [7:0] res;
    logic [3:0] flags;
    logic [3:0] upd;
    logic wr;
    logic mul;
    logic [15:0] prod;
  } asf_calc_t;

endpackage

// ===== logic/asf_calc.sv
`timescale 1ns/1ps
`include "asf_regs.svh"

module asf_calc #(
  parameter bit HAS_MULT = 1'b1
) (
  input asf_pkg::asf_instr_t instr,
  input wire logic [7:0] w,
  input wire logic [7:0] fdata,
  input wire logic cin,
  output asf_pkg::asf_calc_t c
);

  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] x;
  logic [7:0] y;
  logic ci;
  logic arith;
  logic [8:0] s9;
  logic [4:0] n5;

  always_comb begin
    // Single-operand ops take W or the file; two-operand ops pair W with file or literal.
    a = instr.src_w ? w : fdata;
    b = instr.use_imm ? instr.imm : fdata;
    x = 8'h00;
    y = 8'h00;
    ci = 1'b0;
    arith = 1'b1;
    case (instr.op)
      asf_pkg::OP_ADD: begin
        x = w;
        y = b;
      end
      asf_pkg::OP_ADDC: begin
        x = w;
        y = b;
        ci = cin;
      end
      asf_pkg::OP_SUB: begin
        // Two's complement add, so carry out is set when no borrow happened.
        x = b;
        y = ~w;
        ci = 1'b1;
      end
      asf_pkg::OP_INC: begin
        x = a;
        ci = 1'b1;
      end
      asf_pkg::OP_DEC: begin
        x = a;
        y = 8'hff;
      end
      default: arith = 1'b0;
    endcase
    s9 = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    n5 = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    c = '0;
    c.res = s9[7:0];
    c.flags[`ASF_BIT_SIGNED_RANGE] = (x[7] == y[7]) && (s9[7] != x[7]);
    c.flags[`ASF_BIT_HALF_BYTE_BORROW] = n5[4];
    c.flags[`ASF_BIT_C] = s9[8];
    c.upd = arith ? 4'hf : 4'h0;
    c.wr = arith;
    case (instr.op)
      asf_pkg::OP_AND, asf_pkg::OP_IOR, asf_pkg::OP_XOR: begin
        c.res = (instr.op == asf_pkg::OP_AND) ? (w & b) :
                (instr.op == asf_pkg::OP_IOR) ? (w | b) : (w ^ b);
        c.upd = 4'h4;
        c.wr = 1'b1;
      end
      asf_pkg::OP_RLC, asf_pkg::OP_RRC: begin
        c.res = (instr.op == asf_pkg::OP_RLC) ? {a[6:0], cin} : {cin, a[7:1]};
        c.flags[`ASF_BIT_C] = (instr.op == asf_pkg::OP_RLC) ? a[7] : a[0];
        c.upd = 4'h1;
        c.wr = 1'b1;
      end
      asf_pkg::OP_COM, asf_pkg::OP_ZERO_FILL: begin
        c.res = (instr.op == asf_pkg::OP_COM) ? ~a : 8'h00;
        c.upd = 4'h4;
        c.wr = 1'b1;
      end
      asf_pkg::OP_BIT_DROP, asf_pkg::OP_BIT_RAISE, asf_pkg::OP_NIBBLE_EXCHANGE,
      asf_pkg::OP_ACCUM_TO_FILE: begin
        c.res = (instr.op == asf_pkg::OP_BIT_DROP) ? (a & ~(8'h01 << instr.bitsel)) :
                (instr.op == asf_pkg::OP_BIT_RAISE) ? (a | (8'h01 << instr.bitsel)) :
                (instr.op == asf_pkg::OP_NIBBLE_EXCHANGE) ? {a[3:0], a[7:4]} : w;
        c.upd = 4'h0;
        c.wr = 1'b1;
      end
      asf_pkg::OP_MUL: begin
        c.mul = HAS_MULT;
        c.prod = {8'h00, w} * {8'h00, b};
      end
      default: begin
      end
    endcase
    c.flags[`ASF_BIT_Z] = (c.res == 8'h00);
  end

endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`include "asf_regs.svh"

module tb_top;
  typedef struct {
    asf_pkg::asf_op_t op;
    logic imm_sel;
    logic w_sel;
    logic [7:0] imm;
    logic [7:0] fv;
    logic [7:0] w0;
    logic [7:0] s0;
    logic [7:0] ew;
    logic [7:0] es;
  } asf_row_t;

  logic clk, reset_n, wr, rd, op_valid, file_we;
  logic [7:0] addr, wdata, rdata, file_rdata, file_waddr, file_wdata, status, working_accum;
  logic [15:0] prod;
  asf_pkg::asf_instr_t op;
  asf_pkg::asf_step_t ptr0_step, ptr1_step;
  int err_total, n_checks;
  int cycles = 0;
  asf_row_t rows[15];

  asf_core asf_core_i (.CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .OP_VALID(op_valid), .OP(op), .FILE_RDATA(file_rdata),
    .FILE_WE(file_we), .FILE_WADDR(file_waddr), .FILE_WDATA(file_wdata), .STATUS(status),
    .WORKING_ACCUM(working_accum), .PROD(prod), .PTR0_STEP(ptr0_step),
    .PTR1_STEP(ptr1_step));

  // ==========================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The whole sequence needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      test_done();
    end
  end

  // ==========================================================
  // Access tasks
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read data", {8'h00, rdata}, {8'h00, exp});
  endtask

  // The file operand is inverted after the instruction so a stale value never matches.
  task automatic exec(input asf_pkg::asf_op_t o, input logic iu, input logic sw, input logic df,
      input logic [7:0] fa, input logic [7:0] iv, input logic [7:0] fv, input logic [2:0] bs);
    @(posedge clk);
    op_valid <= 1'b1;
    op <= '{op: o, use_imm: iu, src_w: sw, dest_file: df, faddr: fa, imm: iv, bitsel: bs};
    file_rdata <= fv;
    @(posedge clk);
    op_valid <= 1'b0;
    file_rdata <= ~fv;
    #1;
  endtask

  task automatic file_op(input asf_pkg::asf_op_t o, input logic [7:0] fv, input logic [7:0] exp);
    exec(o, 1'b0, 1'b0, 1'b1, 8'h20, 8'h00, fv, 3'h3);
    chk("file we", {15'h0000, file_we}, 16'h0001);
    chk("file addr", {8'h00, file_waddr}, 16'h0020);
    chk("file data", {8'h00, file_wdata}, {8'h00, exp});
    chk("status kept", {8'h00, status}, 16'h005a);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] v;
    reset_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    op_valid = 1'b0;
    op = '0;
    file_rdata = 8'h00;
    err_total = 0;
    n_checks = 0;
    rows = '{
      '{asf_pkg::OP_ADD, 1'h1, 1'h0, 8'h01, 8'h00, 8'h7f, 8'hf0, 8'h80, 8'hfa},
      '{asf_pkg::OP_ADDC, 1'h1, 1'h0, 8'h00, 8'h00, 8'hff, 8'hf1, 8'h00, 8'hf7},
      '{asf_pkg::OP_SUB, 1'h0, 1'h0, 8'h00, 8'h01, 8'h01, 8'hf0, 8'h00, 8'hf7},
      '{asf_pkg::OP_SUB, 1'h0, 1'h0, 8'h00, 8'h00, 8'h01, 8'hf7, 8'hff, 8'hf0},
      '{asf_pkg::OP_SUB, 1'h1, 1'h0, 8'h80, 8'h00, 8'h01, 8'hf0, 8'h7f, 8'hf9},
      '{asf_pkg::OP_AND, 1'h1, 1'h0, 8'ha5, 8'h00, 8'h5a, 8'hf0, 8'h00, 8'hf4},
      '{asf_pkg::OP_IOR, 1'h1, 1'h0, 8'ha5, 8'h00, 8'h5a, 8'hf4, 8'hff, 8'hf0},
      '{asf_pkg::OP_XOR, 1'h1, 1'h0, 8'h5a, 8'h00, 8'h5a, 8'hfb, 8'h00, 8'hff},
      '{asf_pkg::OP_COM, 1'h0, 1'h1, 8'h00, 8'h00, 8'h5a, 8'hf4, 8'ha5, 8'hf0},
      '{asf_pkg::OP_INC, 1'h0, 1'h1, 8'h00, 8'h00, 8'hff, 8'hf0, 8'h00, 8'hf7},
      '{asf_pkg::OP_INC, 1'h0, 1'h0, 8'h00, 8'h0f, 8'h33, 8'hf0, 8'h10, 8'hf2},
      '{asf_pkg::OP_DEC, 1'h0, 1'h1, 8'h00, 8'h00, 8'h80, 8'hf0, 8'h7f, 8'hf9},
      '{asf_pkg::OP_RLC, 1'h0, 1'h1, 8'h00, 8'h00, 8'h80, 8'hf0, 8'h00, 8'hf1},
      '{asf_pkg::OP_RRC, 1'h0, 1'h1, 8'h00, 8'h00, 8'h00, 8'hf1, 8'h80, 8'hf0},
      '{asf_pkg::OP_NOP, 1'h0, 1'h0, 8'h00, 8'h00, 8'h33, 8'hf5, 8'h33, 8'hf5}};
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    chk("status reset", {8'h00, status}, {8'h00, `ASF_STATUS_RST});
    chk("accum reset", {8'h00, working_accum}, 16'h0000);
    chk("prod reset", prod, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      v = {i[1:0], 2'(3 - i), 4'h0};
      bus_wr(`ASF_OFS_STATUS, v);
      bus_rd(`ASF_OFS_STATUS, v);
      chk("ptr0 step", {14'h0000, ptr0_step}, v[5] ? 16'h0002 : {15'h0000, v[4]});
      chk("ptr1 step", {14'h0000, ptr1_step}, v[7] ? 16'h0002 : {15'h0000, v[6]});
    end
    foreach (rows[i]) begin
      bus_wr(`ASF_OFS_STATUS, rows[i].s0);
      bus_wr(`ASF_OFS_WORKING_ACCUM, rows[i].w0);
      exec(rows[i].op, rows[i].imm_sel, rows[i].w_sel, 1'b0, 8'h20, rows[i].imm, rows[i].fv,
        3'h0);
      chk("accum", {8'h00, working_accum}, {8'h00, rows[i].ew});
      chk("status", {8'h00, status}, {8'h00, rows[i].es});
    end
    bus_wr(`ASF_OFS_STATUS, 8'h0b);
    exec(asf_pkg::OP_ZERO_FILL, 1'b0, 1'b0, 1'b1, 8'h04, 8'h00, 8'h0b, 3'h0);
    chk("status clear", {8'h00, status}, 16'h000f);
    chk("no file write", {15'h0000, file_we}, 16'h0000);
    bus_wr(`ASF_OFS_STATUS, 8'hf0);
    bus_wr(`ASF_OFS_WORKING_ACCUM, 8'h1f);
    exec(asf_pkg::OP_ADD, 1'b0, 1'b0, 1'b1, 8'h04, 8'h00, 8'hf0, 3'h0);
    chk("status add", {8'h00, status}, 16'h0001);
    bus_wr(`ASF_OFS_WORKING_ACCUM, 8'h5a);
    exec(asf_pkg::OP_ACCUM_TO_FILE, 1'b0, 1'b0, 1'b1, 8'h04, 8'h00, 8'h01, 3'h0);
    chk("status move", {8'h00, status}, 16'h005a);
    file_op(asf_pkg::OP_BIT_RAISE, 8'h10, 8'h18);
    file_op(asf_pkg::OP_BIT_DROP, 8'hff, 8'hf7);
    file_op(asf_pkg::OP_NIBBLE_EXCHANGE, 8'h3c, 8'hc3);
    file_op(asf_pkg::OP_ACCUM_TO_FILE, 8'h00, 8'h5a);
    bus_wr(`ASF_OFS_WORKING_ACCUM, 8'hff);
    exec(asf_pkg::OP_MUL, 1'b1, 1'b0, 1'b0, 8'h00, 8'hff, 8'h00, 3'h0);
    chk("product", prod, 16'hfe01);
    chk("status mul", {8'h00, status}, 16'h005a);
    exec(asf_pkg::OP_BIT_RAISE, 1'b0, 1'b0, 1'b1, 8'h04, 8'h00, 8'h5a, 3'h2);
    chk("status bit set", {8'h00, status}, 16'h005e);
    chk("bit set no file write", {15'h0000, file_we}, 16'h0000);
    bus_rd(`ASF_OFS_PRODL, 8'h01);
    bus_rd(`ASF_OFS_PRODH, 8'hfe);
    @(posedge clk);
    #1;
    chk("read data idle", {8'h00, rdata}, 16'h0000);
    bus_rd(8'h3c, 8'h00);
    test_done();
  end
endmodule
